// >>> verilog/view_rsz_pkg.sv
// Purpose: constants for the view resizer window and rate registers
// Assumes: 16-bit register port, byte offsets as printed
// Notes:   control and mode registers are included at their printed offsets
package view_rsz_pkg;
   localparam int          AddrWidth      = 12;
   localparam int          DataWidth      = 16;
   localparam int          PosWidth       = 10;
   localparam int          RateWidth      = 6;
   localparam int          ModeWidth      = 2;
   localparam int          FactorWidth    = 6;

   localparam logic [11:0] CtrlOffset     = 12'h940;
   localparam logic [11:0] EndYOffset     = 12'h94a;
   localparam logic [11:0] RateOffset     = 12'h94c;
   localparam logic [11:0] ModeOffset     = 12'h94e;

   localparam int          CtrlEnableBit  = 0;
   localparam int          CtrlVsyncBit   = 1;
   localparam int          CtrlIndepBit   = 2;
   localparam int          EndYLsb        = 0;
   localparam int          HRateLsb       = 0;
   localparam int          VRateLsb       = 8;
   localparam int          ModeLsb        = 0;

   localparam logic [9:0]  EndYReset      = 10'h1df;
   localparam logic [5:0]  HRateReset     = 6'h01;
   localparam logic [5:0]  VRateReset     = 6'h01;
   localparam logic [5:0]  RateMin        = 6'h01;
   localparam logic [5:0]  RateMax        = 6'h20;

   typedef enum logic [1:0]
   {
      ModeNone      = 2'h0,
      ModeReduce    = 2'h1,
      ModeVRedHAvg  = 2'h2,
      ModeReserved  = 2'h3
   } scale_mode_t;

   typedef enum logic [1:0]
   {
      RateValid    = 2'h0,
      RateNotAppl  = 2'h1,
      RateResvd    = 2'h3
   } rate_class_t;
endpackage

// >>> verilog/rate_decode.sv
// Purpose: classify a rate code against the scaling mode
// Assumes: code and mode are already the active (shadowed) values
// Notes:   horizontal averaging allows only power-of-two codes
module rate_decode
   import view_rsz_pkg::*;
#(
   parameter bit HORIZ = 1'b0
)
(
   input  wire logic [RateWidth-1:0]   code,
   input  wire logic [ModeWidth-1:0]   mode,
   output rate_class_t                 rateClass,
   output logic      [FactorWidth-1:0] factor
);
   logic inRange;
   logic pow2;
   logic avgOk;

   assign inRange = (code >= RateMin) && (code <= RateMax);
   assign pow2    = (code & (code - 6'h01)) == 6'h00;
   assign avgOk   = HORIZ ? pow2 : 1'b1;

   always_comb
   begin
      rateClass = RateResvd;
      unique case (scale_mode_t'(mode))
         ModeNone:     rateClass = inRange ? RateNotAppl : RateResvd;
         ModeReduce:   rateClass = inRange ? RateValid : RateResvd;
         ModeVRedHAvg: rateClass = (inRange && avgOk) ? RateValid : RateResvd;
         ModeReserved: rateClass = RateResvd;
      endcase
   end

   // factor N for a 1/N reduction, zero when not usable
   assign factor = (rateClass == RateValid) ? code : 6'h00;
endmodule

// >>> verilog/view_resizer_window_and_rate_regs.sv
// Purpose: end-Y window and scaling-rate registers of the view resizer
// Assumes: register port synchronous to clk_sys, read data one cycle later
// Notes:   active copies follow the written ones at once or at camera vsync
// Operation
// - end-Y holds a 10-bit last vertical line in its low bits, kept in range by software.
// - bit 10 of end-Y is reserved, resets to zero and does nothing.
// - bits 13-8 of the rate register give the vertical rate only with independent scaling on.
// - with independent scaling off, bits 5-0 give both horizontal and vertical rate.
// - with independent scaling on, bits 5-0 give only the horizontal rate.
// - vertical codes 1 to 32 mean 1/N in modes 01 and 10, zero and above 32 are reserved.
// - mode 00 makes codes 1 to 32 not applicable and the others reserved, and mode 11 makes every code reserved.
// - control bit 2 chooses one shared rate or separate horizontal and vertical rates.
// - mode 00 is no scaling, 01 reduction both ways, 10 vertical reduction with horizontal average, 11 reserved.
// - enabling a mode with an unusable rate may turn the view resizer off.
// - with the vsync option set, new window and rate values wait for camera vsync.
module view_resizer_window_and_rate_regs
   import view_rsz_pkg::*;
(
   input  wire logic                   clk_sys,
   input  wire logic                   rst_n,
   input  wire logic [AddrWidth-1:0]   regAddr,
   input  wire logic [DataWidth-1:0]   regWrData,
   input  wire logic                   regWrite,
   input  wire logic                   regRead,
   output logic      [DataWidth-1:0]   regRdData,
   input  wire logic                   camVsync,
   output logic                        resizerEnable,
   output logic      [PosWidth-1:0]    endY,
   output logic      [FactorWidth-1:0] hFactor,
   output logic      [FactorWidth-1:0] vFactor,
   output logic      [ModeWidth-1:0]   scaleMode,
   output logic                        rateError,
   output logic                        resizerActive
);
   logic [2:0]           ctrl_q;
   logic [PosWidth-1:0]  endY_q;
   logic [RateWidth-1:0] hRate_q;
   logic [RateWidth-1:0] vRate_q;
   logic [ModeWidth-1:0] mode_q;
   logic [PosWidth-1:0]  actEndY_q;
   logic [RateWidth-1:0] actHRate_q;
   logic [RateWidth-1:0] actVRate_q;
   logic                 actIndep_q;
   logic [ModeWidth-1:0] actMode_q;
   logic                 vsync_q;
   logic [DataWidth-1:0] rdData_q;

   logic                 selCtrl;
   logic                 selEndY;
   logic                 selRate;
   logic                 selMode;
   logic                 vsyncRise;
   logic                 updateNow;
   logic [RateWidth-1:0] vCode;
   logic [DataWidth-1:0] rdData_d;
   rate_class_t          hClass;
   rate_class_t          vClass;
   logic [FactorWidth-1:0] hFac;
   logic [FactorWidth-1:0] vFac;

   assign selCtrl = regAddr == CtrlOffset;
   assign selEndY = regAddr == EndYOffset;
   assign selRate = regAddr == RateOffset;
   assign selMode = regAddr == ModeOffset;

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl_q  <= 3'h0;
         endY_q  <= EndYReset;
         hRate_q <= HRateReset;
         vRate_q <= VRateReset;
         mode_q  <= 2'h0;
      end
      else if (regWrite)
      begin
         if (selCtrl)
            ctrl_q <= regWrData[2:0];
         if (selEndY)
            endY_q <= regWrData[EndYLsb +: PosWidth];
         if (selRate)
         begin
            hRate_q <= regWrData[HRateLsb +: RateWidth];
            vRate_q <= regWrData[VRateLsb +: RateWidth];
         end
         if (selMode)
            mode_q <= regWrData[ModeLsb +: ModeWidth];
      end
   end

   // vsync sampled as a synchronous input; the edge marks the frame boundary
   assign vsyncRise = camVsync && !vsync_q;
   assign updateNow = !ctrl_q[CtrlVsyncBit] || vsyncRise;

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         vsync_q    <= 1'b0;
         actEndY_q  <= EndYReset;
         actHRate_q <= HRateReset;
         actVRate_q <= VRateReset;
         actIndep_q <= 1'b0;
         actMode_q  <= 2'h0;
      end
      else
      begin
         vsync_q <= camVsync;
         if (updateNow)
         begin
            actEndY_q  <= endY_q;
            actHRate_q <= hRate_q;
            actVRate_q <= vRate_q;
            actIndep_q <= ctrl_q[CtrlIndepBit];
            actMode_q  <= mode_q;
         end
      end
   end

   // shared code unless the directions are split
   assign vCode = actIndep_q ? actVRate_q : actHRate_q;

   rate_decode #(.HORIZ(1'b1)) uHDecode
   (
      .code      (actHRate_q),
      .mode      (actMode_q),
      .rateClass (hClass),
      .factor    (hFac)
   );

   rate_decode #(.HORIZ(1'b0)) uVDecode
   (
      .code      (vCode),
      .mode      (actMode_q),
      .rateClass (vClass),
      .factor    (vFac)
   );

   assign rdData_d = selCtrl ? {13'h0000, ctrl_q} :
                     selEndY ? {6'h00, endY_q} :
                     selRate ? {2'h0, vRate_q, 2'h0, hRate_q} :
                     selMode ? {14'h0000, mode_q} :
                     16'h0000;

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         rdData_q <= 16'h0000;
      else
         rdData_q <= regRead ? rdData_d : 16'h0000;
   end

   // an unusable rate in a scaling mode shuts the datapath off rather than scaling wrongly
   assign rateError     = (actMode_q != ModeNone) && ((hClass != RateValid) || (vClass != RateValid));
   assign regRdData     = rdData_q;
   assign resizerEnable = ctrl_q[CtrlEnableBit];
   assign resizerActive = ctrl_q[CtrlEnableBit] && !rateError;
   assign endY          = actEndY_q;
   assign hFactor       = hFac;
   assign vFactor       = vFac;
   assign scaleMode     = actMode_q;
endmodule

// >>> bench/view_rsz_chk.sv
// Purpose: port checks on the view resizer rate registers
// Assumes: top module ports only
// Notes: a factor of 0 means the code is not usable
module view_rsz_chk
   import view_rsz_pkg::*;
(
   input wire logic        clk_sys,
   input wire logic        rst_n,
   input wire logic [11:0] regAddr,
   input wire logic [15:0] regWrData,
   input wire logic        regWrite,
   input wire logic        regRead,
   input wire logic [15:0] regRdData,
   input wire logic        camVsync,
   input wire logic        resizerEnable,
   input wire logic [9:0]  endY,
   input wire logic [5:0]  hFactor,
   input wire logic [5:0]  vFactor,
   input wire logic [1:0]  scaleMode,
   input wire logic        rateError,
   input wire logic        resizerActive
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   chk_mode_none: assert property (scaleMode == 2'h0 |-> !rateError && hFactor == 6'h0 && vFactor == 6'h0)
      else $error("mode 00 not idle");
   chk_mode_resvd: assert property (scaleMode == 2'h3 |-> rateError && hFactor == 6'h0 && vFactor == 6'h0)
      else $error("mode 11 not refused");
   chk_vrate_range: assert property (vFactor != 6'h0 |-> vFactor <= RateMax)
      else $error("vertical factor out of range");
   chk_avg_pow: assert property (scaleMode == 2'h2 && hFactor != 6'h0 |-> $onehot(hFactor))
      else $error("averaging factor not a power of two");
   chk_bad_rate: assert property (scaleMode != 2'h0 |-> rateError == (hFactor == 6'h0 || vFactor == 6'h0))
      else $error("rate error wrong");
   chk_active_lvl: assert property (resizerActive == (resizerEnable && !rateError))
      else $error("active level wrong");
   chk_rd_idle: assert property (!$past(regRead) |-> regRdData == 16'h0)
      else $error("read data not idle");
   chk_rate_unused: assert property (regRead && regAddr == RateOffset |=> regRdData[15:14] == 2'h0 && regRdData[7:6] == 2'h0)
      else $error("rate unused bits set");
   chk_endy_unused: assert property (regRead && regAddr == EndYOffset |=> regRdData[15:10] == 6'h0)
      else $error("end-Y unused bits set");
   cover property (scaleMode == 2'h1 && resizerActive);
   cover property (scaleMode == 2'h2 && hFactor != 6'h0 && resizerActive);
   cover property (scaleMode == 2'h2 && rateError);
   cover property (camVsync ##1 !camVsync);
endmodule
bind view_resizer_window_and_rate_regs view_rsz_chk chk (.clk_sys, .rst_n, .regAddr, .regWrData, .regWrite, .regRead,
   .regRdData, .camVsync, .resizerEnable, .endY, .hFactor, .vFactor, .scaleMode, .rateError, .resizerActive);

// >>> bench/testbench.sv
// Purpose: directed register test of the view resizer window and rates
// Assumes: read data stand one cycle after the strobe
// Notes: outputs are looked at three edges after a write
module testbench
   import view_rsz_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_sys = 1'b0, rst_n = 1'b0, regWrite = 1'b0, regRead = 1'b0, camVsync = 1'b0;
   logic [11:0] regAddr = 12'h0;
   logic [15:0] regWrData = 16'h0, regRdData;
   logic [9:0]  endY;
   logic [5:0]  hFactor, vFactor;
   logic [1:0]  scaleMode;
   logic        resizerEnable, rateError, resizerActive;
   int          bad_count = 0, num_checks = 0;
   always #2.5 clk_sys = ~clk_sys;
   view_resizer_window_and_rate_regs uut (.clk_sys, .rst_n, .regAddr, .regWrData, .regWrite, .regRead, .regRdData,
      .camVsync, .resizerEnable, .endY, .hFactor, .vFactor, .scaleMode, .rateError, .resizerActive);
   task chk(input string n, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e)
      begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task wr(input logic [11:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge clk_sys);
      regWrite <= 1'b0;
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask
   task rd(input logic [11:0] a, input logic [15:0] e);
      @(posedge clk_sys);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk_sys);
      regRead <= 1'b0;
      @(negedge clk_sys);
      chk("regRdData", e, regRdData);
   endtask
   task outs(input logic [5:0] h, input logic [5:0] v, input logic e, input logic a);
      chk("outputs", {2'h0, h, v, e, a}, {2'h0, hFactor, vFactor, rateError, resizerActive});
   endtask
   task ctl(input logic [1:0] m, input logic en);
      chk("scaleMode resizerEnable", {13'h0000, m, en}, {13'h0000, scaleMode, resizerEnable});
   endtask
   task close_out;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial
   begin
      repeat (20) @(posedge clk_sys);
      rst_n <= 1'b1;
      rd(EndYOffset, 16'h01df);
      rd(RateOffset, 16'h0101);
      outs(6'h0, 6'h0, 1'b0, 1'b0);
      ctl(2'h0, 1'b0);
      wr(EndYOffset, 16'hffff);
      rd(EndYOffset, 16'h03ff);
      chk("endY", 16'h03ff, {6'h0, endY});
      wr(RateOffset, 16'hffff);
      rd(RateOffset, 16'h3f3f);
      rd(12'h950, 16'h0000);
      wr(RateOffset, 16'h0305);
      wr(CtrlOffset, 16'h0001);
      wr(ModeOffset, 16'h0001);
      rd(ModeOffset, 16'h0001);
      ctl(2'h1, 1'b1);
      outs(6'h05, 6'h05, 1'b0, 1'b1);
      wr(CtrlOffset, 16'h0005);
      rd(CtrlOffset, 16'h0005);
      outs(6'h05, 6'h03, 1'b0, 1'b1);
      wr(ModeOffset, 16'h0002);
      outs(6'h00, 6'h03, 1'b1, 1'b0);
      wr(ModeOffset, 16'h0003);
      outs(6'h00, 6'h00, 1'b1, 1'b0);
      ctl(2'h3, 1'b1);
      // sweep every vertical code in both reducing modes; horizontal code 1 is legal in both
      for (int m = 1; m < 3; m++)
      begin
         wr(ModeOffset, 16'(m));
         for (int n = 0; n < 64; n++)
         begin
            wr(RateOffset, {2'h0, 6'(n), 8'h01});
            outs(6'h01, (n >= 1 && n <= 32) ? 6'(n) : 6'h0, !(n >= 1 && n <= 32), n >= 1 && n <= 32);
         end
      end
      rd(ModeOffset, 16'h0002);
      wr(RateOffset, 16'h0404);
      wr(CtrlOffset, 16'h0007);
      wr(RateOffset, 16'h0202);
      wr(EndYOffset, 16'h0100);
      outs(6'h04, 6'h04, 1'b0, 1'b1);
      chk("endY", 16'h03ff, {6'h0, endY});
      ctl(2'h2, 1'b1);
      @(posedge clk_sys);
      camVsync <= 1'b1;
      @(posedge clk_sys);
      camVsync <= 1'b0;
      repeat (2) @(posedge clk_sys);
      #1 outs(6'h02, 6'h02, 1'b0, 1'b1);
      chk("endY", 16'h0100, {6'h0, endY});
      // reset again mid-run: everything must fall back to its reset value
      @(posedge clk_sys);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(negedge clk_sys);
      outs(6'h0, 6'h0, 1'b0, 1'b0);
      chk("endY", 16'h01df, {6'h0, endY});
      ctl(2'h0, 1'b0);
      rd(EndYOffset, 16'h01df);
      rd(RateOffset, 16'h0101);
      rd(CtrlOffset, 16'h0000);
      close_out;
   end
   // run needs about 620 cycles, limit leaves ample slack
   initial
   begin
      #20000;
      bad_count++;
      close_out;
   end
endmodule
